// ==== logic/dbcsp_pkg.sv ====
// Shared constants for the burst-of-two common-I/O SRAM port and its controller.
// Assumes both ends run on one clock and that the link clock is a data signal.
package dbcsp_pkg;

  // ----------------------------------------------------------------
  // Organisation
  // ----------------------------------------------------------------
  localparam int LANE_W = 9;
  localparam int DW_X36 = 36;
  localparam int DW_X18 = 18;
  localparam int AW_X36 = 21;
  localparam int BURST_STEP = 1;
  localparam int FIFO_DEPTH = 16;

  // ----------------------------------------------------------------
  // Pipeline positions, counted in link clock edges after the command, then pipeline and buffer sizes
  // ----------------------------------------------------------------
  localparam int POS_WR_BEAT0 = 2;
  localparam int POS_WR_BEAT1 = 3;
  localparam int POS_RD_LOAD0 = 3;
  localparam int POS_RD_LOAD1 = 4;
  localparam int POS_RD_CAP0 = 5;
  localparam int POS_RD_CAP1 = 6;
  localparam int DEV_PIPE_LEN = 5;
  localparam int CTRL_PIPE_LEN = 7;
  localparam int WR_SLOTS = 4;
  localparam int BUF_ENTRIES = 2;

  // ----------------------------------------------------------------
  // Reset levels
  // ----------------------------------------------------------------
  localparam logic KCLK_RST = 1'h0;
  localparam logic LOAD_IDLE_N = 1'h1;

  typedef enum logic [1:0]
  {
    CTL_RUN = 2'h0,
    CTL_DRAIN = 2'h1,
    CTL_HALT = 2'h3
  } dbcsp_state_e;

endpackage : dbcsp_pkg

// ==== logic/dbcsp_link_if.sv ====
// Link between the SRAM port and its memory controller.
// Assumes one clock; the shared data bus level is resolved here from the enables.
`timescale 1ns/1ps
interface dbcsp_link_if #(
  parameter int DW = dbcsp_pkg::DW_X36,
  parameter int AW = dbcsp_pkg::AW_X36
) ();
  logic kClk;
  logic loadStrobeN;
  logic rdWrN;
  logic [AW-1:0] addr;
  logic [DW/dbcsp_pkg::LANE_W-1:0] byteWriteEnableN;
  logic [DW-1:0] ctrlDq;
  logic ctrlOe;
  logic [DW-1:0] devDq;
  logic devOe;
  logic [DW-1:0] dqWire;
  logic busClash;

  // The device wins a clash so a read is never silently lost. A bus that
  // nobody drives shows the inverse of the last write, so a stray sample shows up.
  assign dqWire = devOe ? devDq : (ctrlOe ? ctrlDq : ~ctrlDq);
  assign busClash = devOe & ctrlOe;

  modport dev (
    input kClk, loadStrobeN, rdWrN, addr, byteWriteEnableN, dqWire,
    output devDq, devOe
  );

  modport ctrl (
    input dqWire,
    output kClk, loadStrobeN, rdWrN, addr, byteWriteEnableN, ctrlDq, ctrlOe
  );
endinterface : dbcsp_link_if

// ==== logic/dbcsp_device.sv ====
// Device end: command decode, burst addressing, late-write buffers and read data.
// Assumes the controller shares mclk and toggles kClk at most once per cycle.
`timescale 1ns/1ps

// How it works
// - Second beat address is first plus one.
// - Load low, read-not-write high starts read.
// - Load low, read-not-write low starts write.
// - Load high is no operation, bus released.
// - Stopped clock holds both data beats.
// - Controller leaves one gap from read to write.
// - Two lane enables select nine-bit halves.
// - Four lane enables select nine-bit quarters.
// - Beat enables sampled at edges two, three.
// - Two newest writes buffered, reads see them.
module dbcsp_device #(
  parameter int DW = dbcsp_pkg::DW_X36,
  parameter int AW = dbcsp_pkg::AW_X36
) (
  dbcsp_link_if.dev link, // Command and data link.
  input wire logic mclk, // System clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic ce, // Clock enable; low freezes all state.
  output logic [dbcsp_pkg::BUF_ENTRIES-1:0] bufValid // Write buffer entries in use.
);
  import dbcsp_pkg::*;

  localparam int NB = DW / LANE_W;
  typedef logic [DW-1:0] dbcsp_word_t;
  typedef logic [AW-1:0] dbcsp_addr_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic dbcsp_word_t laneMask(input logic [NB-1:0] beN);
    dbcsp_word_t m;
    m = '0;
    for (int i = 0; i < NB; i++)
    begin
      m[i*LANE_W +: LANE_W] = {LANE_W{~beN[i]}};
    end
    return m;
  endfunction : laneMask

  function automatic dbcsp_word_t merge(input dbcsp_word_t old, input dbcsp_word_t nw,
                                        input dbcsp_word_t m);
    return (old & ~m) | (nw & m);
  endfunction : merge

  function automatic dbcsp_addr_t nextAddr(input dbcsp_addr_t a);
    return a + AW'(BURST_STEP);
  endfunction : nextAddr

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic kPrev_q;
  logic kPrev_d;
  logic [DEV_PIPE_LEN-1:0] sVld_q;
  logic [DEV_PIPE_LEN-1:0] sVld_d;
  logic [DEV_PIPE_LEN-1:0] sRd_q;
  logic [DEV_PIPE_LEN-1:0] sRd_d;
  dbcsp_addr_t sAddr_q [DEV_PIPE_LEN];
  dbcsp_addr_t sAddr_d [DEV_PIPE_LEN];
  dbcsp_word_t wd0_q;
  dbcsp_word_t wd0_d;
  dbcsp_word_t wm0_q;
  dbcsp_word_t wm0_d;
  logic [BUF_ENTRIES-1:0] bufValid_q;
  logic [BUF_ENTRIES-1:0] bufValid_d;
  dbcsp_addr_t bAddr_q [BUF_ENTRIES];
  dbcsp_addr_t bAddr_d [BUF_ENTRIES];
  dbcsp_word_t bD0_q [BUF_ENTRIES];
  dbcsp_word_t bD0_d [BUF_ENTRIES];
  dbcsp_word_t bD1_q [BUF_ENTRIES];
  dbcsp_word_t bD1_d [BUF_ENTRIES];
  dbcsp_word_t bM0_q [BUF_ENTRIES];
  dbcsp_word_t bM0_d [BUF_ENTRIES];
  dbcsp_word_t bM1_q [BUF_ENTRIES];
  dbcsp_word_t bM1_d [BUF_ENTRIES];
  dbcsp_word_t dq_q;
  dbcsp_word_t dq_d;
  logic oe_q;
  logic oe_d;
  dbcsp_word_t mem [2**AW];

  logic linkEdge;
  logic riseEdge;
  logic cmdNow;
  logic rdLoad0;
  logic rdLoad1;
  logic wrBeat0;
  logic wrBeat1;
  logic commit;
  dbcsp_addr_t lookAddr;
  dbcsp_word_t lookData;

  // ----------------------------------------------------------------
  // Link edge and command decode
  // ----------------------------------------------------------------
  // The link clock arrives from logic on mclk, so it is compared raw.
  // With no edge nothing below moves, which holds both data beats.
  // Hold when stopped
  assign linkEdge = link.kClk != kPrev_q;
  assign riseEdge = linkEdge & link.kClk;
  assign cmdNow = riseEdge & ~link.loadStrobeN;

  always_comb
  begin
    kPrev_d = link.kClk;
    sVld_d = sVld_q;
    sRd_d = sRd_q;
    sAddr_d = sAddr_q;
    if (linkEdge)
    begin
      sVld_d = {sVld_q[DEV_PIPE_LEN-2:0], cmdNow};
      sRd_d = {sRd_q[DEV_PIPE_LEN-2:0], link.rdWrN};
      sAddr_d[0] = link.addr;
      for (int i = 1; i < DEV_PIPE_LEN; i++)
      begin
        sAddr_d[i] = sAddr_q[i-1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Beat decode
  // ----------------------------------------------------------------
  // Commands enter only on rising edges, so occupied slots share one
  // parity and the two read loads never coincide.
  // Read and write beat timing
  assign rdLoad0 = linkEdge & sVld_d[POS_RD_LOAD0] & sRd_d[POS_RD_LOAD0];
  assign rdLoad1 = linkEdge & sVld_d[POS_RD_LOAD1] & sRd_d[POS_RD_LOAD1];
  assign wrBeat0 = linkEdge & sVld_d[POS_WR_BEAT0] & ~sRd_d[POS_WR_BEAT0];
  assign wrBeat1 = linkEdge & sVld_d[POS_WR_BEAT1] & ~sRd_d[POS_WR_BEAT1];
  assign commit = wrBeat1 & bufValid_q[BUF_ENTRIES-1];

  // ----------------------------------------------------------------
  // Coherent read lookup
  // ----------------------------------------------------------------
  always_comb
  begin
    lookAddr = rdLoad0 ? sAddr_d[POS_RD_LOAD0] : nextAddr(sAddr_d[POS_RD_LOAD1]);
    lookData = mem[lookAddr];
    for (int i = BUF_ENTRIES - 1; i >= 0; i--)
    begin
      if (bufValid_q[i] && lookAddr == bAddr_q[i])
      begin
        lookData = merge(lookData, bD0_q[i], bM0_q[i]);
      end
      if (bufValid_q[i] && lookAddr == nextAddr(bAddr_q[i]))
      begin
        lookData = merge(lookData, bD1_q[i], bM1_q[i]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Write capture, buffers and read drive
  // ----------------------------------------------------------------
  always_comb
  begin
    wd0_d = wd0_q;
    wm0_d = wm0_q;
    bufValid_d = bufValid_q;
    bAddr_d = bAddr_q;
    bD0_d = bD0_q;
    bD1_d = bD1_q;
    bM0_d = bM0_q;
    bM1_d = bM1_q;
    dq_d = dq_q;
    oe_d = oe_q;
    if (wrBeat0)
    begin
      wd0_d = link.dqWire;
      wm0_d = laneMask(link.byteWriteEnableN);
    end
    if (wrBeat1)
    begin
      bufValid_d = {bufValid_q[BUF_ENTRIES-2:0], 1'h1};
      for (int i = 1; i < BUF_ENTRIES; i++)
      begin
        bAddr_d[i] = bAddr_q[i-1];
        bD0_d[i] = bD0_q[i-1];
        bD1_d[i] = bD1_q[i-1];
        bM0_d[i] = bM0_q[i-1];
        bM1_d[i] = bM1_q[i-1];
      end
      bAddr_d[0] = sAddr_d[POS_WR_BEAT1];
      bD0_d[0] = wd0_q;
      bM0_d[0] = wm0_q;
      bD1_d[0] = link.dqWire;
      bM1_d[0] = laneMask(link.byteWriteEnableN);
    end
    if (linkEdge)
    begin
      oe_d = rdLoad0 | rdLoad1;
      if (rdLoad0 || rdLoad1)
      begin
        dq_d = lookData;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      kPrev_q <= KCLK_RST;
      sVld_q <= '0;
      sRd_q <= '0;
      sAddr_q <= '{default: '0};
      wd0_q <= '0;
      wm0_q <= '0;
      bufValid_q <= '0;
      bAddr_q <= '{default: '0};
      bD0_q <= '{default: '0};
      bD1_q <= '{default: '0};
      bM0_q <= '{default: '0};
      bM1_q <= '{default: '0};
      dq_q <= '0;
      oe_q <= 1'h0;
    end
    else if (ce)
    begin
      kPrev_q <= kPrev_d;
      sVld_q <= sVld_d;
      sRd_q <= sRd_d;
      sAddr_q <= sAddr_d;
      wd0_q <= wd0_d;
      wm0_q <= wm0_d;
      bufValid_q <= bufValid_d;
      bAddr_q <= bAddr_d;
      bD0_q <= bD0_d;
      bD1_q <= bD1_d;
      bM0_q <= bM0_d;
      bM1_q <= bM1_d;
      dq_q <= dq_d;
      oe_q <= oe_d;
    end
  end

  // The array is plain storage and is not cleared by reset.
  // The top address plus one wraps to zero; there is no wrap option.
  always_ff @(posedge mclk)
  begin
    if (ce && !srst && commit)
    begin
      mem[bAddr_q[1]] <= merge(mem[bAddr_q[1]], bD0_q[1], bM0_q[1]);
      mem[nextAddr(bAddr_q[1])] <= merge(mem[nextAddr(bAddr_q[1])], bD1_q[1], bM1_q[1]);
    end
  end

  assign link.devDq = dq_q;
  assign link.devOe = oe_q;
  assign bufValid = bufValid_q;

endmodule : dbcsp_device

// ==== logic/dbcsp_ctrl.sv ====
// Controller end: issues commands, drives write beats, collects read beats.
// Assumes the device shares mclk; kClk is made here by toggling each cycle except in CTL_HALT.
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Read data FIFO
// ----------------------------------------------------------------
module dbcsp_fifo #(
  parameter int W = dbcsp_pkg::DW_X36,
  parameter int DEPTH = dbcsp_pkg::FIFO_DEPTH
) (
  input wire logic mclk, // System clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic ce, // Clock enable.
  input wire logic inValid, // Write word offered.
  output logic inReady, // Room for a word.
  input wire logic [W-1:0] inData, // Word to store.
  output logic outValid, // Word available.
  input wire logic outReady, // Consumer takes the word.
  output logic [W-1:0] outData, // Oldest word.
  output logic [$clog2(DEPTH):0] free // Free entries.
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] wp_d;
  logic [PW-1:0] rp_q;
  logic [PW-1:0] rp_d;
  logic [PW:0] cnt_q;
  logic [PW:0] cnt_d;
  logic push;
  logic pop;

  assign inReady = cnt_q != (PW+1)'(DEPTH);
  assign outValid = cnt_q != '0;
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  always_comb
  begin
    wp_d = push ? PW'((wp_q + 1'h1) % DEPTH) : wp_q;
    rp_d = pop ? PW'((rp_q + 1'h1) % DEPTH) : rp_q;
    cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else if (ce)
    begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (ce && push)
    begin
      mem[wp_q] <= inData;
    end
  end

  assign outData = mem[rp_q];
  assign free = (PW+1)'(DEPTH) - cnt_q;
endmodule : dbcsp_fifo

// ----------------------------------------------------------------
// Controller
// ----------------------------------------------------------------
module dbcsp_ctrl #(
  parameter int DW = dbcsp_pkg::DW_X36,
  parameter int AW = dbcsp_pkg::AW_X36,
  parameter int DEPTH = dbcsp_pkg::FIFO_DEPTH
) (
  dbcsp_link_if.ctrl link, // Command and data link.
  input wire logic mclk, // System clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic ce, // Clock enable; low freezes all state.
  input wire logic reqValid, // Request offered.
  output logic reqReady, // Request taken this cycle.
  input wire logic reqRead, // 1 read, 0 write.
  input wire logic [AW-1:0] reqAddr, // First beat address.
  input wire logic [DW-1:0] reqData0, // Write data, first beat.
  input wire logic [DW-1:0] reqData1, // Write data, second beat.
  input wire logic [DW/dbcsp_pkg::LANE_W-1:0] reqBeN0, // Lane enables, first beat.
  input wire logic [DW/dbcsp_pkg::LANE_W-1:0] reqBeN1, // Lane enables, second beat.
  input wire logic stopReq, // Ask to stop the link clock.
  output logic clkStopped, // Link clock is stopped.
  output logic rdValid, // Read word available.
  input wire logic rdReady, // Consumer takes the read word.
  output logic [DW-1:0] rdData // Read word, beats in order.
);
  import dbcsp_pkg::*;

  localparam int NB = DW / LANE_W;
  localparam int FW = $clog2(DEPTH) + 1;

  dbcsp_state_e st_q;
  dbcsp_state_e st_d;
  logic kClk_q;
  logic kClk_d;
  logic [CTRL_PIPE_LEN-1:0] sVld_q;
  logic [CTRL_PIPE_LEN-1:0] sVld_d;
  logic [CTRL_PIPE_LEN-1:0] sRd_q;
  logic [CTRL_PIPE_LEN-1:0] sRd_d;
  logic [DW-1:0] sD0_q [WR_SLOTS];
  logic [DW-1:0] sD0_d [WR_SLOTS];
  logic [DW-1:0] sD1_q [WR_SLOTS];
  logic [DW-1:0] sD1_d [WR_SLOTS];
  logic [NB-1:0] sB0_q [WR_SLOTS];
  logic [NB-1:0] sB0_d [WR_SLOTS];
  logic [NB-1:0] sB1_q [WR_SLOTS];
  logic [NB-1:0] sB1_d [WR_SLOTS];
  logic ldN_q;
  logic ldN_d;
  logic rw_q;
  logic rw_d;
  logic [AW-1:0] addr_q;
  logic [AW-1:0] addr_d;
  logic [NB-1:0] beN_q;
  logic [NB-1:0] beN_d;
  logic [DW-1:0] dq_q;
  logic [DW-1:0] dq_d;
  logic oe_q;
  logic oe_d;

  logic advance;
  logic rise;
  logic canRead;
  logic canWrite;
  logic issue;
  logic capture;
  logic fifoReady;
  logic [FW-1:0] fifoFree;
  logic [FW-1:0] rdsInPipe;

  always_comb
  begin
    rdsInPipe = '0;
    for (int i = 0; i < CTRL_PIPE_LEN; i++)
    begin
      rdsInPipe = rdsInPipe + FW'(sVld_q[i] & sRd_q[i]);
    end
  end

  assign advance = st_q != CTL_HALT;
  assign rise = advance & ~kClk_q;
  // Room for every beat already in flight plus this burst, so the FIFO
  // never overflows when the consumer stalls.
  assign canRead = fifoReady && fifoFree >= FW'(2) * (rdsInPipe + FW'(1));
  // Read then write needs one gap
  assign canWrite = !(sVld_q[POS_WR_BEAT0-1] && sRd_q[POS_WR_BEAT0-1]);
  assign reqReady = ce && rise && st_q == CTL_RUN && (reqRead ? canRead : canWrite);
  assign issue = reqValid & reqReady;
  assign capture = advance && ((sVld_d[POS_RD_CAP0] && sRd_d[POS_RD_CAP0])
                 || (sVld_d[POS_RD_CAP1] && sRd_d[POS_RD_CAP1]));

  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      CTL_RUN: if (stopReq) st_d = CTL_DRAIN;
      CTL_DRAIN: if (sVld_q == '0) st_d = CTL_HALT;
      CTL_HALT: if (!stopReq) st_d = CTL_RUN;
      default: st_d = CTL_RUN;
    endcase
  end

  always_comb
  begin
    kClk_d = advance ? ~kClk_q : kClk_q;
    sVld_d = sVld_q;
    sRd_d = sRd_q;
    sD0_d = sD0_q;
    sD1_d = sD1_q;
    sB0_d = sB0_q;
    sB1_d = sB1_q;
    ldN_d = ldN_q;
    rw_d = rw_q;
    addr_d = addr_q;
    beN_d = beN_q;
    dq_d = dq_q;
    oe_d = oe_q;
    if (advance)
    begin
      sVld_d = {sVld_q[CTRL_PIPE_LEN-2:0], issue};
      sRd_d = {sRd_q[CTRL_PIPE_LEN-2:0], reqRead};
      sD0_d[0] = reqData0;
      sD1_d[0] = reqData1;
      sB0_d[0] = reqBeN0;
      sB1_d[0] = reqBeN1;
      for (int i = 1; i < WR_SLOTS; i++)
      begin
        sD0_d[i] = sD0_q[i-1];
        sD1_d[i] = sD1_q[i-1];
        sB0_d[i] = sB0_q[i-1];
        sB1_d[i] = sB1_q[i-1];
      end
      ldN_d = ~issue;
      if (issue)
      begin
        rw_d = reqRead;
        addr_d = reqAddr;
      end
      beN_d = '1;
      oe_d = 1'h0;
      if (sVld_d[POS_WR_BEAT0] && !sRd_d[POS_WR_BEAT0])
      begin
        beN_d = sB0_d[POS_WR_BEAT0];
        dq_d = sD0_d[POS_WR_BEAT0];
        oe_d = 1'h1;
      end
      else if (sVld_d[POS_WR_BEAT1] && !sRd_d[POS_WR_BEAT1])
      begin
        beN_d = sB1_d[POS_WR_BEAT1];
        dq_d = sD1_d[POS_WR_BEAT1];
        oe_d = 1'h1;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      st_q <= CTL_RUN;
      kClk_q <= KCLK_RST;
      sVld_q <= '0;
      sRd_q <= '0;
      sD0_q <= '{default: '0};
      sD1_q <= '{default: '0};
      sB0_q <= '{default: '1};
      sB1_q <= '{default: '1};
      ldN_q <= LOAD_IDLE_N;
      rw_q <= 1'h1;
      addr_q <= '0;
      beN_q <= '1;
      dq_q <= '0;
      oe_q <= 1'h0;
    end
    else if (ce)
    begin
      st_q <= st_d;
      kClk_q <= kClk_d;
      sVld_q <= sVld_d;
      sRd_q <= sRd_d;
      sD0_q <= sD0_d;
      sD1_q <= sD1_d;
      sB0_q <= sB0_d;
      sB1_q <= sB1_d;
      ldN_q <= ldN_d;
      rw_q <= rw_d;
      addr_q <= addr_d;
      beN_q <= beN_d;
      dq_q <= dq_d;
      oe_q <= oe_d;
    end
  end

  dbcsp_fifo #(
    .W(DW),
    .DEPTH(DEPTH)
  ) u_rdFifo (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .inValid(capture),
    .inReady(fifoReady),
    .inData(link.dqWire),
    .outValid(rdValid),
    .outReady(rdReady),
    .outData(rdData),
    .free(fifoFree)
  );

  assign link.kClk = kClk_q;
  assign link.loadStrobeN = ldN_q;
  assign link.rdWrN = rw_q;
  assign link.addr = addr_q;
  assign link.byteWriteEnableN = beN_q;
  assign link.ctrlDq = dq_q;
  assign link.ctrlOe = oe_q;
  assign clkStopped = st_q == CTL_HALT;

endmodule : dbcsp_ctrl

// ==== bench/dbcsp_link_assertions.sv ====
// Concurrent checks on the link between the SRAM port and its controller.
// Assumes one clock domain and signals taken straight from the link interface.
`timescale 1ns/1ps
module dbcsp_link_assertions #(
  parameter int DW = dbcsp_pkg::DW_X36
) (
  input wire logic mclk, // System clock.
  input wire logic srst, // Synchronous reset.
  input wire logic kClk, // Link clock.
  input wire logic loadStrobeN, // Command load, low active.
  input wire logic rdWrN, // Read high, write low.
  input wire logic [DW/dbcsp_pkg::LANE_W-1:0] byteWriteEnableN, // Lane enables.
  input wire logic ctrlOe, // Controller drives the bus.
  input wire logic [DW-1:0] devDq, // Device data.
  input wire logic devOe, // Device drives the bus.
  input wire logic busClash // Both ends drive.
);
  import dbcsp_pkg::*;
  logic kPrev_q;
  logic kPrev_d;
  logic rdCmd;
  logic wrCmd;

  always_comb
  begin
    kPrev_d = srst ? 1'b0 : kClk;
  end

  always_ff @(posedge mclk)
  begin
    kPrev_q <= kPrev_d;
  end

  // Commands count only on a rising link clock, so a falling one never looks like a command.
  assign rdCmd = kClk & ~kPrev_q & ~loadStrobeN & rdWrN;
  assign wrCmd = kClk & ~kPrev_q & ~loadStrobeN & ~rdWrN;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  property p_noClash; !busClash; endproperty
  a_noClash: assert property (p_noClash)
    else $error("both ends drive the data bus");
  property p_rdBeats; rdCmd |-> ##4 devOe [*2]; endproperty
  a_rdBeats: assert property (p_rdBeats)
    else $error("read beats not driven at link edges four and five");
  property p_devOeCause; devOe |-> $past(rdCmd, 4) || $past(rdCmd, 5); endproperty
  a_devOeCause: assert property (p_devOeCause)
    else $error("device drives the bus without a read");
  property p_wrBeats; wrCmd |-> ##2 ctrlOe [*2]; endproperty
  a_wrBeats: assert property (p_wrBeats)
    else $error("write beats not at link edges two and three");
  property p_ctrlOeCause; ctrlOe |-> $past(wrCmd, 2) || $past(wrCmd, 3); endproperty
  a_ctrlOeCause: assert property (p_ctrlOeCause)
    else $error("controller drives the bus without a write");
  property p_wrNoDev; wrCmd |-> ##2 !devOe [*2]; endproperty
  a_wrNoDev: assert property (p_wrNoDev)
    else $error("device drives during write beats");
  property p_rdThenNop; rdCmd |-> ##2 !wrCmd; endproperty
  a_rdThenNop: assert property (p_rdThenNop)
    else $error("write issued on the rise right after a read");
  property p_loadOnRise; !kClk |-> loadStrobeN; endproperty
  a_loadOnRise: assert property (p_loadOnRise)
    else $error("load strobe active on a falling link clock");
  property p_beIdle; !ctrlOe |-> (&byteWriteEnableN); endproperty
  a_beIdle: assert property (p_beIdle)
    else $error("lane enables active outside write beats");
  property p_stopHold; $stable(kClk) [*2] |-> $stable(devDq) && $stable(devOe); endproperty
  a_stopHold: assert property (p_stopHold)
    else $error("data beats change while the link clock is still");

  c_read: cover property (rdCmd);
  c_write: cover property (wrCmd);
  c_wrThenRd: cover property (wrCmd ##2 rdCmd);
  c_stopped: cover property ($stable(kClk) [*4]);
endmodule : dbcsp_link_assertions

// ==== bench/tb_top.sv ====
// Self-checking bench joining the SRAM port and its controller back to back.
// Assumes the design package and link interface are compiled first.
`timescale 1ns/1ps
module tb_top;
  import dbcsp_pkg::*;
  localparam int DW = DW_X36;
  localparam int AW = 6;
  localparam int NB = DW / LANE_W;
  localparam logic [DW-1:0] A0 = 36'h123456789;
  localparam logic [DW-1:0] A1 = 36'hFEDCBA987;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic stopReq = 1'b0;
  logic reqValid = 1'b0;
  logic reqRead = 1'b0;
  logic [AW-1:0] reqAddr = 6'h00;
  logic [DW-1:0] reqData0 = 36'h0;
  logic [DW-1:0] reqData1 = 36'h0;
  logic [NB-1:0] reqBeN0 = 4'hF;
  logic [NB-1:0] reqBeN1 = 4'hF;
  logic rdReady = 1'b0;
  logic reqReady;
  logic clkStopped;
  logic rdValid;
  logic [DW-1:0] rdData;
  logic [1:0] bufValid;
  int badCount = 0;
  int checks = 0;
  int cyc = 0;
  int lastWait = 0;

  dbcsp_link_if #(.DW(DW), .AW(AW)) dbcsp_link_if_inst ();
  dbcsp_device #(.DW(DW), .AW(AW)) dbcsp_device_inst (.link(dbcsp_link_if_inst), .mclk(mclk),
    .srst(srst), .ce(ce), .bufValid(bufValid));
  dbcsp_ctrl #(.DW(DW), .AW(AW), .DEPTH(FIFO_DEPTH)) dbcsp_ctrl_inst (.link(dbcsp_link_if_inst),
    .mclk(mclk), .srst(srst), .ce(ce), .reqValid(reqValid), .reqReady(reqReady),
    .reqRead(reqRead), .reqAddr(reqAddr), .reqData0(reqData0), .reqData1(reqData1),
    .reqBeN0(reqBeN0), .reqBeN1(reqBeN1), .stopReq(stopReq), .clkStopped(clkStopped),
    .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData));
  dbcsp_link_assertions #(.DW(DW)) dbcsp_link_assertions_inst (.mclk(mclk), .srst(srst),
    .kClk(dbcsp_link_if_inst.kClk), .loadStrobeN(dbcsp_link_if_inst.loadStrobeN),
    .rdWrN(dbcsp_link_if_inst.rdWrN), .byteWriteEnableN(dbcsp_link_if_inst.byteWriteEnableN),
    .ctrlOe(dbcsp_link_if_inst.ctrlOe), .devDq(dbcsp_link_if_inst.devDq),
    .devOe(dbcsp_link_if_inst.devOe), .busClash(dbcsp_link_if_inst.busClash));

  initial
  begin
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic endSim;
    $display("checks %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : endSim

  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      badCount++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // Inputs change on falling edges; reqReady is settled there and the next rise takes it.
  task automatic req(input logic rd, input logic [AW-1:0] a, input logic [DW-1:0] d0,
    input logic [DW-1:0] d1, input logic [NB-1:0] b0, input logic [NB-1:0] b1);
    @(negedge mclk);
    {reqValid, reqRead, reqAddr, reqData0, reqData1, reqBeN0, reqBeN1} =
      {1'b1, rd, a, d0, d1, b0, b1};
    lastWait = 0;
    // Let reqReady follow the new reqRead before it is looked at.
    #1;
    while (reqReady !== 1'b1 && lastWait < 40)
    begin
      @(negedge mclk);
      lastWait++;
    end
    @(negedge mclk);
    reqValid = 1'b0;
  endtask : req

  task automatic pop(input logic [DW-1:0] exp);
    int n;
    n = 0;
    @(negedge mclk);
    while (rdValid !== 1'b1 && n < 40)
    begin
      @(negedge mclk);
      n++;
    end
    check(rdData, exp, "read word");
    rdReady = 1'b1;
    @(negedge mclk);
    rdReady = 1'b0;
  endtask : pop

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // basic transfer.
  task automatic sBasic;
    req(1'b0, 6'h05, A0, A1, 4'h0, 4'h0);
    req(1'b1, 6'h05, 36'h0, 36'h0, 4'hF, 4'hF);
    pop(A0);
    pop(A1);
    check(DW'(bufValid), DW'(2'h1), "one write buffered");
  endtask : sBasic

  // back-to-back reads until the FIFO refuses, then drain with the consumer stalling.
  task automatic sFifo;
    for (int i = 0; i < 8; i++) req(1'b1, 6'h05, 36'h0, 36'h0, 4'hF, 4'hF);
    req(1'b1, 6'h05, 36'h0, 36'h0, 4'hF, 4'hF);
    check(DW'(lastWait), DW'(40), "full read buffer refuses");
    for (int i = 0; i < 8; i++)
    begin
      pop(A0);
      pop(A1);
    end
  endtask : sFifo

  // all lanes off aborts both beats.
  task automatic sAbort;
    req(1'b0, 6'h05, 36'h0, 36'h0, 4'hF, 4'hF);
    req(1'b1, 6'h05, 36'h0, 36'h0, 4'hF, 4'hF);
    pop(A0);
    pop(A1);
    check(DW'(bufValid), DW'(2'h3), "two writes buffered");
  endtask : sAbort

  // one lane per beat, read while buffered and after commit.
  task automatic sLanes;
    logic [AW-1:0] a;
    for (int i = 0; i < 4; i++)
    begin
      a = AW'(16 + 2 * i);
      req(1'b0, a, 36'h0, 36'h0, 4'h0, 4'h0);
      req(1'b0, a, 36'hFFFFFFFFF, 36'hFFFFFFFFF, ~(4'h1 << i), ~(4'h1 << ((i + 1) % 4)));
      req(1'b1, a, 36'h0, 36'h0, 4'hF, 4'hF);
      pop(36'h1FF << (LANE_W * i));
      pop(36'h1FF << (LANE_W * ((i + 1) % 4)));
    end
    req(1'b1, 6'h10, 36'h0, 36'h0, 4'hF, 4'hF);
    pop(36'h0000001FF);
    pop(36'h00003FE00);
  endtask : sLanes

  // second beat wraps to address zero.
  task automatic sWrap;
    req(1'b0, 6'h00, 36'h111111111, 36'h222222222, 4'h0, 4'h0);
    req(1'b0, 6'h3F, 36'h333333333, 36'h444444444, 4'h0, 4'h0);
    req(1'b1, 6'h00, 36'h0, 36'h0, 4'hF, 4'hF);
    pop(36'h444444444);
    pop(36'h222222222);
  endtask : sWrap

  // stopped clock keeps the bus idle, then traffic resumes.
  task automatic sStop;
    logic k;
    int n;
    req(1'b0, 6'h08, A1, A0, 4'h0, 4'h0);
    stopReq = 1'b1;
    n = 0;
    while (clkStopped !== 1'b1 && n < 40)
    begin
      @(negedge mclk);
      n++;
    end
    check(DW'(clkStopped), DW'(1'b1), "link clock stopped after drain");
    k = dbcsp_link_if_inst.kClk;
    repeat (6)
    begin
      @(negedge mclk);
      check(DW'(dbcsp_link_if_inst.kClk), DW'(k), "link clock frozen");
      check(DW'(dbcsp_link_if_inst.devOe), 36'h0, "bus released");
    end
    stopReq = 1'b0;
    req(1'b1, 6'h08, 36'h0, 36'h0, 4'hF, 4'hF);
    pop(A1);
    pop(A0);
  endtask : sStop

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      badCount++;
      endSim();
    end
  end

  initial
  begin
    repeat (10) @(negedge mclk);
    srst = 1'b0;
    sBasic();
    sFifo();
    sAbort();
    sLanes();
    sWrap();
    sStop();
    endSim();
  end
endmodule : tb_top
